// ==== rtl/cip_pkg.sv ====
/*
 Shared constants for the SRAM-window block cipher engine and its host.
 Assumes both ends run on MCLK at 40 MHz and share one address map.
*/
package cip_pkg;
  // Window map: status, control, sixteen data bytes, control copy
  localparam logic [7:0] ADDR_STATUS = 8'h82;
  localparam logic [7:0] ADDR_CTRL = 8'h83;
  localparam logic [7:0] ADDR_DATA_LO = 8'h84;
  localparam logic [7:0] ADDR_DATA_HI = 8'h93;
  localparam logic [7:0] ADDR_MIRROR = 8'h94;
  // Control byte fields
  localparam int CTRL_REQ = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_MODE = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MODE_ECB = 2'h0;
  localparam logic [1:0] MODE_KEY = 2'h1;
  localparam logic [1:0] MODE_CBC = 2'h2;
  // Link command bytes
  localparam logic [7:0] CMD_SRAM_WR = 8'h40;
  localparam logic [7:0] CMD_SRAM_RD = 8'h00;
  // Timing
  localparam int CLK_MHZ = 40;
  localparam real T_AES_US = 23.4;
  localparam int AES_CYC = int'(T_AES_US * CLK_MHZ);
  localparam int ROUNDS = 10;
  localparam logic [7:0] RCON_FIRST = 8'h01;
  localparam logic [7:0] RCON_LAST = 8'h36;
  localparam int SCLK_HALF = 8;
  // Host APB map and fields
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_TX = 8'h04;
  localparam logic [7:0] HOST_STAT = 8'h08;
  localparam logic [7:0] HOST_RX = 8'h0c;
  localparam int HC_OPEN = 0;
  localparam int HC_WRITE = 1;
  localparam int HC_CLOSE = 2;
  localparam int HC_ADDR = 8;
endpackage

// ==== rtl/cip_link_if.sv ====
/*
 Serial link between host and cipher engine.
 Assumes the engine drives miso only while its enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
interface cip_link_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic miso;
  // Undriven line reads low
  assign miso = miso_oe & miso_drv;
  modport dev (input sclk, input sel_n, input mosi, output miso_drv,
    output miso_oe);
  modport host (output sclk, output sel_n, output mosi, input miso);
endinterface
`default_nettype wire

// ==== rtl/cip_engine.sv ====
/*
 Block cipher engine reached only through SRAM-style bursts on the link.
 Assumes the link pins are asynchronous to MCLK and that the power state
 inputs come from logic on MCLK.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Engine reached only via window 0x82..0x94
// - Data block lives at 0x84..0x93
// - Request bit at 0x83 or 0x94 starts
// - Mode, data, start in one burst
// - No access needed outside the window
// - Sleep, deep_power_down_state, reset refuse access
// - Deep_power_down_state or reset clears everything
// - Touching 0x83 while running aborts
// - Initial key kept separately, reused each run
// - Engine independent of radio datapath
// - Fast access writes and reads together
// - Host loads key in key mode first
// - Mode field and direction bit applied
// - Host order: key, mode, data, start, read
// - Standard 128-bit cipher, 128-bit key
// - Code book both ways, chaining encrypt only
// - Mode 2 chains previous result by XOR
// - Direction 0 means encrypt
// - Write shifts out old byte, one lag
// - One block takes about 23.4 us
module cip_engine import cip_pkg::*; #(
  parameter int AES_CYCLES = AES_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SLEEP_STATE,
  input wire logic DEEP_POWER_DOWN_STATE,
  input wire logic RESET_STATE,
  output logic BUSY,
  output logic DONE,
  cip_link_if.dev link
);
  logic [2:0] sclk_s, sel_s, mosi_s;
  logic [2:0] bitcnt;
  logic [6:0] rx;
  logic [1:0] bidx;
  logic wr_mode, miso_oe;
  logic [7:0] addr, prep, tx, ctrl, rc;
  logic [127:0] st, ikey, rk, res;
  logic [9:0] cnt;
  logic busy, done, dec;
  logic blocked, clr, active, rise, fall, acc;
  logic [7:0] rx_byte;
  logic [127:0] enc_s, enc_k, enc_n, dec_s, dec_k, dec_t, dec_n;
  logic [1:0] wmode;
  logic [3:0] widx;

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction
  function automatic logic [7:0] xti(input logic [7:0] a);
    return {1'b0, a[7:1]} ^ (a[0] ? 8'h8d : 8'h00);
  endfunction
  function automatic logic [7:0] gmul(input logic [7:0] a,
      input logic [7:0] b);
    logic [7:0] p, x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction
  function automatic logic [7:0] rl(input logic [7:0] x, input int n);
    logic [15:0] t;
    t = {x, x} << n;
    return t[15:8];
  endfunction
  // S-box from the field inverse, so no table is stored
  function automatic logic [7:0] sbox(input logic [7:0] x, input logic inv);
    logic [7:0] a, r;
    a = inv ? (rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ 8'h05) : x;
    r = 8'h01;
    for (int i = 7; i >= 0; i--) begin
      r = gmul(r, r);
      if (i != 0) r = gmul(r, a);
    end
    return inv ? r : (r ^ rl(r, 1) ^ rl(r, 2) ^ rl(r, 3) ^ rl(r, 4) ^ 8'h63);
  endfunction
  // Byte i of a block, byte 0 first on the link
  function automatic logic [7:0] gb(input logic [127:0] v, input int i);
    return v[127-8*i -: 8];
  endfunction
  function automatic logic [127:0] sub_shift(input logic [127:0] v,
      input logic inv);
    logic [127:0] o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? ((c + 4 - r) % 4) * 4 + r : ((c + r) % 4) * 4 + r;
        o[127-8*(c*4+r) -: 8] = sbox(gb(v, src), inv);
      end
    end
    return o;
  endfunction
  function automatic logic [127:0] mix(input logic [127:0] v,
      input logic inv);
    logic [127:0] o;
    logic [7:0] a;
    logic [31:0] cf;
    o = '0;
    cf = inv ? 32'h0e0b0d09 : 32'h02030101;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        a = 8'h00;
        for (int k = 0; k < 4; k++) begin
          a = a ^ gmul(cf[31-8*((k+4-r)%4) -: 8], gb(v, c*4+k));
        end
        o[127-8*(c*4+r) -: 8] = a;
      end
    end
    return o;
  endfunction
  // Round key one step forward, or one step back for decryption
  function automatic logic [127:0] kstep(input logic [127:0] k,
      input logic [7:0] c, input logic inv);
    logic [31:0] w3, t;
    logic [127:0] o;
    w3 = inv ? (k[31:0] ^ k[63:32]) : k[31:0];
    t = {sbox(w3[23:16], 1'b0) ^ c, sbox(w3[15:8], 1'b0),
      sbox(w3[7:0], 1'b0), sbox(w3[31:24], 1'b0)};
    if (!inv) begin
      o[127:96] = k[127:96] ^ t;
      o[95:64] = k[95:64] ^ o[127:96];
      o[63:32] = k[63:32] ^ o[95:64];
      o[31:0] = w3 ^ o[63:32];
    end else begin
      o[127:96] = k[127:96] ^ t;
      o[95:64] = k[95:64] ^ k[127:96];
      o[63:32] = k[63:32] ^ k[95:64];
      o[31:0] = w3;
    end
    return o;
  endfunction
  // Read view of the window; key page shows the last round key
  function automatic logic [7:0] rdb(input logic [7:0] a);
    logic [7:0] c;
    logic [3:0] ix;
    c = ctrl;
    c[CTRL_REQ] = busy;
    // Four-bit offset, so 0x90..0x93 wrap to bytes 12..15
    ix = a[3:0] - 4'h4;
    if (a == ADDR_STATUS) return {7'h00, done};
    if (a == ADDR_CTRL || a == ADDR_MIRROR) return c;
    if (a >= ADDR_DATA_LO && a <= ADDR_DATA_HI) begin
      return (ctrl[CTRL_MODE +: 2] == MODE_KEY) ? gb(rk, int'(ix))
        : gb(st, int'(ix));
    end
    return 8'h00;
  endfunction

  // Link inputs cross into MCLK through two flops
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sclk_s <= 3'h0;
      sel_s <= 3'h7;
      mosi_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      sel_s <= {sel_s[1:0], link.sel_n};
      mosi_s <= {mosi_s[1:0], link.mosi};
    end
  end

  assign blocked = SLEEP_STATE | DEEP_POWER_DOWN_STATE | RESET_STATE;
  assign clr = DEEP_POWER_DOWN_STATE | RESET_STATE;
  assign active = ~sel_s[1] & ~blocked;
  assign rise = sclk_s[1] & ~sclk_s[2];
  assign fall = ~sclk_s[1] & sclk_s[2];
  assign rx_byte = {rx, mosi_s[1]};
  assign acc = active & rise & (bitcnt == 3'h7) & (bidx == 2'h2);
  assign wmode = rx_byte[CTRL_MODE +: 2];
  // Byte offset in the block; kept at four bits so it wraps past 0x8f
  assign widx = addr[3:0] - 4'h4;
  assign link.miso_drv = tx[7];
  assign link.miso_oe = miso_oe;
  assign BUSY = busy;
  assign DONE = done;

  // Serial front end: command, address, then auto-incremented bytes
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bitcnt <= 3'h0;
      rx <= 7'h00;
      bidx <= 2'h0;
      wr_mode <= 1'b0;
      addr <= 8'h00;
      prep <= 8'h00;
      tx <= 8'h00;
      miso_oe <= 1'b0;
    end else if (!active) begin
      bitcnt <= 3'h0;
      bidx <= 2'h0;
      miso_oe <= 1'b0;
      tx <= rdb(ADDR_STATUS); // Status leads every frame
    end else begin
      miso_oe <= 1'b1;
      if (rise) begin
        bitcnt <= bitcnt + 3'h1;
        rx <= rx_byte[6:0];
        if (bitcnt == 3'h7) begin
          unique case (bidx)
            2'h0: begin
              wr_mode <= (rx_byte == CMD_SRAM_WR);
              bidx <= 2'h1;
              prep <= 8'h00;
            end
            2'h1: begin
              addr <= rx_byte;
              bidx <= 2'h2;
              prep <= 8'h00;
              if (!wr_mode) prep <= rdb(rx_byte);
            end
            default: begin
              addr <= addr + 8'h01;
              // Old content leaves one byte behind the new one
              prep <= wr_mode ? rdb(addr) : rdb(addr + 8'h01);
            end
          endcase
        end
      end
      if (fall) tx <= (bitcnt == 3'h0) ? prep : {tx[6:0], 1'b0};
    end
  end

  // Round datapath, one round per clock
  always_comb begin
    enc_s = sub_shift(st, 1'b0);
    enc_k = kstep(rk, rc, 1'b0);
    enc_n = (cnt == 10'(ROUNDS)) ? (enc_s ^ enc_k)
      : (mix(enc_s, 1'b0) ^ enc_k);
    dec_s = sub_shift(st, 1'b1);
    dec_k = kstep(rk, rc, 1'b1);
    dec_t = dec_s ^ dec_k;
    dec_n = (cnt == 10'(ROUNDS)) ? dec_t : mix(dec_t, 1'b1);
  end

  // Window registers and cipher sequencing; runs on through sleep, cleared by deep power down or reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      st <= '0;
      ikey <= '0;
      rk <= '0;
      res <= '0;
      rc <= 8'h00;
      cnt <= 10'h000;
      busy <= 1'b0;
      done <= 1'b0;
      dec <= 1'b0;
    end else if (clr) begin
      ctrl <= CTRL_RESET;
      st <= '0;
      ikey <= '0;
      rk <= '0;
      res <= '0;
      rc <= 8'h00;
      cnt <= 10'h000;
      busy <= 1'b0;
      done <= 1'b0;
      dec <= 1'b0;
    end else begin
      if (busy) begin
        cnt <= cnt + 10'h001;
        if (cnt == 10'h000) begin
          st <= st ^ rk;
        end else if (cnt <= 10'(ROUNDS)) begin
          st <= dec ? dec_n : enc_n;
          rk <= dec ? dec_k : enc_k;
          rc <= dec ? xti(rc) : xt(rc);
        end
        // Result is held back to the documented block time
        if (cnt == 10'(AES_CYCLES - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          res <= st;
        end
      end
      if (acc && wr_mode && (addr == ADDR_CTRL || addr == ADDR_MIRROR)) begin
        ctrl <= rx_byte & ~(8'h01 << CTRL_REQ);
        if (busy && addr == ADDR_CTRL) begin
          busy <= 1'b0;
        end else if (!busy && rx_byte[CTRL_REQ] && wmode != MODE_KEY) begin
          busy <= 1'b1;
          done <= 1'b0;
          cnt <= 10'h000;
          rk <= ikey;
          // Chaining always encrypts; direction 0 is encrypt
          dec <= rx_byte[CTRL_DIR] && wmode != MODE_CBC;
          rc <= (rx_byte[CTRL_DIR] && wmode != MODE_CBC) ? RCON_LAST
            : RCON_FIRST;
          if (wmode == MODE_CBC) st <= st ^ res;
        end
      end else if (acc && wr_mode && !busy && addr >= ADDR_DATA_LO &&
          addr <= ADDR_DATA_HI) begin
        // Key page fills the held initial key, else the data block
        if (ctrl[CTRL_MODE +: 2] == MODE_KEY) begin
          ikey[127-8*widx -: 8] <= rx_byte;
        end else begin
          st[127-8*widx -: 8] <= rx_byte;
        end
      end else if (acc && !wr_mode && busy && addr == ADDR_CTRL) begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/cip_host.sv ====
/*
 Host end: APB slave that opens SRAM bursts and moves bytes over the link.
 Assumes software follows the key, mode, data, start, read order.
*/
`timescale 1ns/1ps
`default_nettype none
module cip_host import cip_pkg::*; #(
  parameter int HALF = SCLK_HALF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TRX_BLOCKED,
  cip_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b100
  } cip_spi_e;
  cip_spi_e hs;
  logic [1:0] miso_s, pend;
  logic [3:0] cnt;
  logic [2:0] nbit;
  logic [7:0] sh, rx_last, addr;
  logic open_f, wr_f, refused, sclk, sel_n, mosi;
  logic req, tx_ok, ld;
  logic [7:0] ld_byte;
  logic [31:0] rd_mux;

  assign link.sclk = sclk;
  assign link.sel_n = sel_n;
  assign link.mosi = mosi;
  assign req = PSEL & PENABLE & ~PREADY;
  assign tx_ok = (hs == H_IDLE) && (pend == 2'h0);
  // Header bytes go first, so mode, data and start follow in write order
  assign ld_byte = (pend == 2'h2) ? (wr_f ? CMD_SRAM_WR : CMD_SRAM_RD)
    : (pend == 2'h1) ? addr : PWDATA[7:0];
  assign ld = (hs == H_IDLE) && (pend != 2'h0 || (req && PWRITE && tx_ok &&
    PADDR == HOST_TX && open_f));

  always_comb begin
    unique case (PADDR)
      HOST_CTRL: rd_mux = {16'h0000, addr, 6'h00, wr_f, open_f};
      HOST_STAT: rd_mux = {29'h0, refused, open_f, ~tx_ok};
      HOST_RX: rd_mux = {24'h000000, rx_last};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Returning data crosses in through two flops
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) miso_s <= 2'h0;
    else miso_s <= {miso_s[0], link.miso};
  end

  // Bus slave and byte shifter share the load decision
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hs <= H_IDLE;
      pend <= 2'h0;
      cnt <= 4'h0;
      nbit <= 3'h0;
      sh <= 8'h00;
      rx_last <= 8'h00;
      addr <= 8'h00;
      open_f <= 1'b0;
      wr_f <= 1'b0;
      refused <= 1'b0;
      sclk <= 1'b0;
      sel_n <= 1'b1;
      mosi <= 1'b0;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      unique case (hs)
        H_IDLE: begin
          if (ld) begin
            sh <= ld_byte;
            mosi <= ld_byte[7];
            cnt <= 4'h0;
            nbit <= 3'h0;
            hs <= H_LOW;
            if (pend != 2'h0) pend <= pend - 2'h1;
          end
        end
        H_LOW: begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'(HALF - 1)) begin
            cnt <= 4'h0;
            sclk <= 1'b1;
            hs <= H_HIGH;
          end
        end
        H_HIGH: begin
          cnt <= cnt + 4'h1;
          // Sample late in the high phase, well after the far end settles
          if (cnt == 4'(HALF - 1)) begin
            cnt <= 4'h0;
            sclk <= 1'b0;
            sh <= {sh[6:0], miso_s[1]};
            mosi <= sh[6];
            nbit <= nbit + 3'h1;
            hs <= H_LOW;
            if (nbit == 3'h7) begin
              rx_last <= {sh[6:0], miso_s[1]};
              hs <= H_IDLE;
            end
          end
        end
      endcase
      if (req && !PWRITE) begin
        PREADY <= 1'b1;
        PRDATA <= rd_mux;
        PSLVERR <= (rd_mux == 32'h0) && PADDR != HOST_CTRL &&
          PADDR != HOST_STAT && PADDR != HOST_RX;
      end else if (req && tx_ok) begin
        // Writes stall until the shifter and header are idle
        PREADY <= 1'b1;
        if (PADDR == HOST_CTRL) begin
          if (PWDATA[HC_CLOSE]) begin
            open_f <= 1'b0;
            sel_n <= 1'b1;
          end else if (PWDATA[HC_OPEN] && !open_f) begin
            // No access while the transceiver sleeps or is held in reset
            if (TRX_BLOCKED || PWDATA[HC_ADDR +: 8] < ADDR_STATUS ||
                PWDATA[HC_ADDR +: 8] > ADDR_MIRROR) begin
              refused <= 1'b1;
              PSLVERR <= 1'b1;
            end else begin
              refused <= 1'b0;
              open_f <= 1'b1;
              sel_n <= 1'b0;
              wr_f <= PWDATA[HC_WRITE];
              addr <= PWDATA[HC_ADDR +: 8];
              pend <= 2'h2;
            end
          end
        end else if (PADDR != HOST_TX || !open_f) begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/cip_link_sva.sv ====
/*
 Checker on the link between host and cipher engine.
 Assumes it sits beside the interface instance and sees the engine flags.
*/
`timescale 1ns/1ps
`default_nettype none
module cip_link_sva #(
  parameter int AES_CYCLES = 936
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic SLEEP_STATE,
  input wire logic DEEP_POWER_DOWN_STATE,
  input wire logic RESET_STATE
);
  int unsigned run_cnt;
  logic blocked;
  logic clr;
  // Power states that lock the engine out
  assign clr = DEEP_POWER_DOWN_STATE | RESET_STATE;
  assign blocked = clr | SLEEP_STATE;
  // Length of the current run, zero when idle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_cnt <= 0;
    end else if (BUSY) begin
      run_cnt <= run_cnt + 1;
    end else begin
      run_cnt <= 0;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  a_sclk_in_frame: assert property ($rose(sclk) |-> !sel_n)
    else $error("link clock edge outside a frame");
  a_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("mosi moved at a sampling edge");
  // Sync depth plus output register needs a few idle edges
  a_idle_quiet: assert property (sel_n[*6] |-> !miso_oe && !sclk)
    else $error("link active outside a frame");
  a_blocked_off: assert property (blocked[*3] |-> !miso_oe)
    else $error("engine answered while locked out");
  a_clear_state: assert property (
    $rose(clr) |-> ##[1:3] (!BUSY && !DONE))
    else $error("power state did not clear the engine");
  a_start_framed: assert property (
    $rose(BUSY) |-> !$past(sel_n, 3) && !DONE)
    else $error("run started outside a frame or with done set");
  a_run_length: assert property (
    $rose(DONE) |-> $past(BUSY) && run_cnt + 1 >= AES_CYCLES &&
    run_cnt <= AES_CYCLES + 1)
    else $error("run length wrong at completion");
  a_run_bound: assert property (run_cnt <= AES_CYCLES + 1)
    else $error("run lasted too long");
  a_done_holds: assert property (DONE && !clr |=> DONE || BUSY)
    else $error("done dropped without a new start");
  c_done: cover property ($rose(DONE));
  c_abort: cover property ($fell(BUSY) && !DONE);
  c_frame: cover property ($fell(sel_n));
  c_deep: cover property ($rose(DEEP_POWER_DOWN_STATE));
endmodule
`default_nettype wire

// ==== verif/block_cipher_sram_mapped_engine_tb.sv ====
/*
 Self-checking bench: host and engine joined by the link, driven over APB.
 Assumes the engine keeps its default run length and the host its divider.
*/
`timescale 1ns/1ps
`default_nettype none
module block_cipher_sram_mapped_engine_tb import cip_pkg::*;;
  typedef logic [7:0] cip_q_t[$];
  localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] LRK = 128'h13111d7fe3944a17f307a78b4d2b30c5;
  localparam logic [127:0] CT0 = 128'h66e94bd4ef8a2c3b884cfa59ca342b2e;
  logic MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic TRX_BLOCKED = 1'b0, SLEEP_STATE = 1'b0, RESET_STATE = 1'b0;
  logic DEEP_POWER_DOWN_STATE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, rdata;
  logic PREADY, PSLVERR, BUSY, DONE, perr;
  cip_q_t rxq;
  int errors = 0, n_checks = 0, cyc = 0;
  cip_link_if cip_link_if_i ();
  cip_engine cip_engine_i (.MCLK(MCLK), .RST(RST), .SLEEP_STATE(SLEEP_STATE),
    .DEEP_POWER_DOWN_STATE(DEEP_POWER_DOWN_STATE), .RESET_STATE(RESET_STATE),
    .BUSY(BUSY), .DONE(DONE), .link(cip_link_if_i.dev));
  cip_host cip_host_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TRX_BLOCKED(TRX_BLOCKED),
    .link(cip_link_if_i.host));
  cip_link_sva #(.AES_CYCLES(AES_CYC)) cip_link_sva_i (.MCLK(MCLK), .RST(RST),
    .sclk(cip_link_if_i.sclk), .sel_n(cip_link_if_i.sel_n),
    .mosi(cip_link_if_i.mosi), .miso_oe(cip_link_if_i.miso_oe), .BUSY(BUSY),
    .DONE(DONE), .SLEEP_STATE(SLEEP_STATE), .RESET_STATE(RESET_STATE),
    .DEEP_POWER_DOWN_STATE(DEEP_POWER_DOWN_STATE));
  // 40 MHz system clock
  initial begin
    forever #12.5 MCLK = ~MCLK;
  end
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Guard against a hung handshake; sized well above the full sequence
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] bt(input logic [127:0] v, input int i);
    return v[127 - 8 * i -: 8];
  endfunction
  // One APB transfer; holds the request until the slave answers
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    rdata = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Send one byte, wait until it has left, then fetch the reply
  task automatic xfer(input logic [7:0] b);
    apb(HOST_TX, 1'b1, {24'h0, b});
    apb(HOST_STAT, 1'b0, 32'h0);
    while (rdata[0] !== 1'b0) apb(HOST_STAT, 1'b0, 32'h0);
    apb(HOST_RX, 1'b0, 32'h0);
    rxq.push_back(rdata[7:0]);
  endtask
  task automatic burst(input logic [7:0] a, input logic w, input cip_q_t d);
    rxq = {};
    apb(HOST_CTRL, 1'b1, {16'h0, a, 6'h0, w, 1'b1});
    foreach (d[i]) xfer(d[i]);
    apb(HOST_CTRL, 1'b1, 32'h4);
    repeat (4) @(posedge MCLK);
  endtask
  // Control byte, block, and optionally the start through the copy
  task automatic run(input logic [7:0] c, input logic [127:0] v,
      input logic go);
    cip_q_t q;
    q.push_back(c);
    for (int i = 0; i < 16; i++) q.push_back(bt(v, i));
    // The copy mirrors the control byte, so it repeats mode and direction
    if (go) q.push_back(c | 8'h01);
    burst(ADDR_CTRL, 1'b1, q);
  endtask
  task automatic rd_res(input logic [7:0] st, input logic [7:0] c,
      input logic [127:0] v);
    cip_q_t z;
    for (int i = 0; i < 18; i++) z.push_back(8'h00);
    burst(ADDR_STATUS, 1'b0, z);
    chk(rxq[0], st);
    chk(rxq[1], c);
    for (int i = 0; i < 16; i++) chk(rxq[i + 2], bt(v, i));
  endtask
  task automatic wdone();
    for (int i = 0; i < 2 * AES_CYC && DONE !== 1'b1; i++) @(posedge MCLK);
    chk(DONE, 1'b1);
  endtask
  task automatic t_regs();
    apb(HOST_STAT, 1'b0, 32'h0);
    chk(rdata[2:0], 3'h0);
    apb(8'h10, 1'b0, 32'h0);
    chk(perr, 1'b1);
    apb(HOST_CTRL, 1'b1, {16'h0, 8'h81, 8'h03});
    chk(perr, 1'b1);
    apb(HOST_CTRL, 1'b1, {16'h0, 8'h95, 8'h03});
    chk(perr, 1'b1);
  endtask
  task automatic t_ops();
    cip_q_t q;
    run(8'h04, KEY, 1'b0);
    run(8'h00, PT, 1'b1);
    wdone();
    rd_res(8'h01, 8'h00, CT);
    // Fast access: new block in, previous result out one byte behind
    for (int i = 0; i < 16; i++) q.push_back(bt(PT, i));
    q.push_back(8'h01);
    burst(ADDR_DATA_LO, 1'b1, q);
    for (int i = 1; i < 17; i++) chk(rxq[i], bt(CT, i - 1));
    wdone();
    rd_res(8'h01, 8'h00, CT);
    run(8'h08, PT ^ CT, 1'b1);
    wdone();
    rd_res(8'h01, 8'h08, CT);
    run(8'h04, LRK, 1'b0);
    run(8'h02, CT, 1'b1);
    wdone();
    rd_res(8'h01, 8'h02, PT);
  endtask
  task automatic t_power();
    TRX_BLOCKED <= 1'b1;
    apb(HOST_CTRL, 1'b1, {16'h0, ADDR_CTRL, 8'h03});
    chk(perr, 1'b1);
    apb(HOST_STAT, 1'b0, 32'h0);
    chk(rdata[2:1], 2'h2);
    TRX_BLOCKED <= 1'b0;
    SLEEP_STATE <= 1'b1;
    run(8'h00, KEY, 1'b1);
    SLEEP_STATE <= 1'b0;
    rd_res(8'h01, 8'h02, PT);
    DEEP_POWER_DOWN_STATE <= 1'b1;
    repeat (8) @(posedge MCLK);
    DEEP_POWER_DOWN_STATE <= 1'b0;
    rd_res(8'h00, 8'h00, 128'h0);
    run(8'h00, 128'h0, 1'b1);
    wdone();
    rd_res(8'h01, 8'h00, CT0);
    RESET_STATE <= 1'b1;
    repeat (8) @(posedge MCLK);
    RESET_STATE <= 1'b0;
    rd_res(8'h00, 8'h00, 128'h0);
  endtask
  // Touching the control byte mid-run must cancel it without done
  task automatic t_abort();
    cip_q_t q;
    q.push_back(8'h00);
    run(8'h00, PT, 1'b1);
    chk(BUSY, 1'b1);
    burst(ADDR_CTRL, 1'b0, q);
    chk(BUSY, 1'b0);
    repeat (AES_CYC + 64) @(posedge MCLK);
    chk(DONE, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    t_regs();
    t_ops();
    t_power();
    t_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
